// ===== bench/peer_node_model.sv
`default_nettype none
module peer_node_model #(
  parameter int unsigned DELAY = 3,
  parameter logic [31:0] SLP   = 32'h0000_0028,
  parameter logic [31:0] WAK   = 32'h0000_001e,
  parameter logic [7:0]  VER   = 8'h01
) (
  // clock and reset
  input wire logic   mclk,
  input wire logic   resetn,
  // triggers
  input wire logic   tx_req,
  input wire logic   kick,
  // sync towards the node
  output logic        rx_sync_valid,
  output logic [31:0] rx_sync_sleep,
  output logic [31:0] rx_sync_wake,
  output logic [7:0]  rx_sync_ver
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned cnt;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt           <= 0;
      rx_sync_valid <= 1'b0;
    end else begin
      rx_sync_valid <= (cnt == 1);
      if (tx_req || kick) cnt <= DELAY;
      else if (cnt != 0) cnt <= cnt - 1;
    end
  end
  // off-frame lines carry the inverse so stale data never looks valid
  assign rx_sync_sleep = rx_sync_valid ? SLP : ~SLP;
  assign rx_sync_wake  = rx_sync_valid ? WAK : ~WAK;
  assign rx_sync_ver   = rx_sync_valid ? VER : ~VER;
endmodule : peer_node_model
`default_nettype wire

// ===== bench/sleep_sync_chk.sv
`default_nettype none
module sleep_sync_chk (
  // clock and reset
  input wire logic        mclk,
  input wire logic        resetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // link and state
  input wire logic        tx_sync,
  input wire logic [31:0] tx_sync_sleep,
  input wire logic [31:0] tx_sync_wake,
  input wire logic [7:0]  tx_sync_ver,
  input wire logic        tx_req,
  input wire logic        awake,
  input wire logic        status_frame
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////
  wait_one_a: assert property ($rose(psel && penable) |-> !pready ##1 pready)
    else $error("apb wait state wrong");
  rdy_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  rdy_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response malformed");
  tx_pulse_a: assert property (tx_sync |=> !tx_sync)
    else $error("tx_sync longer than a cycle");
  // sync contents may only move together with a sync being sent
  tx_hold_a: assert property (!tx_sync |-> $stable({tx_sync_sleep, tx_sync_wake, tx_sync_ver}))
    else $error("sync settings moved without a sync");
  req_pulse_a: assert property (tx_req |=> !tx_req)
    else $error("tx_req longer than a cycle");
  req_awake_a: assert property (tx_req |-> ##[0:2] awake)
    else $error("sync request while asleep");
  frame_pulse_a: assert property (status_frame |=> !status_frame)
    else $error("status frame longer than a cycle");
  ////////////////////////////////////////////////////////////////
  cov_sync_c: cover property (tx_sync);
  cov_req_c: cover property (tx_req);
  cov_err_c: cover property (pready && pslverr);
  cov_frame_c: cover property (status_frame);
endmodule : sleep_sync_chk
bind mesh_sleep_sync_controller sleep_sync_chk u_chk (.mclk, .resetn, .psel, .penable,
  .prdata, .pready, .pslverr, .tx_sync, .tx_sync_sleep, .tx_sync_wake, .tx_sync_ver,
  .tx_req, .awake, .status_frame);
`default_nettype wire

// ===== bench/test_mesh_sleep_sync_controller.sv
`default_nettype none
module test_mesh_sleep_sync_controller;
  timeunit 1ns;
  timeprecision 1ns;
  import sleep_sync_pkg::*;
  logic        mclk, resetn, psel, penable, pwrite, button, rx_req_valid, kick;
  logic [7:0]  paddr, rx_sync_ver, tx_sync_ver;
  logic [31:0] pwdata, prdata, rx_sync_sleep, rx_sync_wake, tx_sync_sleep, tx_sync_wake;
  logic        pready, pslverr, rx_sync_valid, tx_sync, tx_req, awake, led;
  logic        status_frame, status_wake;
  int          failures, checks_done, cyc, frames, frame_bad;

  mesh_sleep_sync_controller #(.MS_CYCLES(10)) u_dut (.mclk, .resetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .button, .rx_sync_valid,
    .rx_sync_sleep, .rx_sync_wake, .rx_sync_ver, .rx_req_valid, .tx_sync, .tx_sync_sleep,
    .tx_sync_wake, .tx_sync_ver, .tx_req, .awake, .led, .status_frame, .status_wake);
  peer_node_model u_peer (.mclk, .resetn, .tx_req, .kick, .rx_sync_valid, .rx_sync_sleep,
    .rx_sync_wake, .rx_sync_ver);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // hang guard, well above the longest path through the scenarios
  always @(posedge mclk) begin
    cyc++;
    if (status_frame === 1'b1) frames++;
    // a wake frame goes out with the node awake, a sleep frame with it asleep
    if (status_frame === 1'b1 && status_wake !== awake) frame_bad++;
    if (cyc == 90000) begin
      failures++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // no wait-state budget: only the hang guard ends a stuck access
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string n);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(n, r, x);
  endtask : rd
  task automatic wait_on(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge mclk);
      n++;
    end
  endtask : wait_on
  task automatic press();
    button <= 1'b1;
    repeat (5) @(posedge mclk);
    button <= 1'b0;
    repeat (15) @(posedge mclk);
  endtask : press
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    chk("awake", awake, 1);
    rd(OFF_CTRL, 32'h0, "ctrl");
    rd(OFF_WAKE, WAKE_RST, "wake");
    rd(OFF_PROP, NN_RST * NH_RST * (MT_RST + 1) * SYNC_UNIT_MS, "prop");
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk("unmapped_err", e, 1);
  endtask : t_reset
  task automatic t_wake_min();
    wr(OFF_NET, 32'h0000_0101);
    rd(OFF_PROP, 32'd18, "prop_small");
    wr(OFF_WAKE, 32'd10);
    wr(OFF_SLEEP, 32'd40);
    rd(OFF_WAKE, 32'd18, "wake_raised");
  endtask : t_wake_min
  task automatic t_cyclic();
    logic [31:0] r;
    logic e;
    int n;
    wr(OFF_CTRL, 32'h0000_0188);
    wait_on(tx_req, 1'b1, 20);
    chk("tx_req", tx_req, 1);
    repeat (10) @(posedge mclk);
    apb(1'b0, OFF_STATUS, 32'h0, r, e);
    chk("status_synced", r[2:0], 3'b110);
    rd(OFF_OP_SLP, 32'd40, "op_sleep");
    rd(OFF_OP_WAK, 32'd30, "op_wake");
    rx_req_valid <= 1'b1;
    @(posedge mclk);
    rx_req_valid <= 1'b0;
    @(posedge mclk);
    chk("reply", tx_sync, 1);
    chk("reply_sleep", tx_sync_sleep, 32'd40);
    wait_on(awake, 1'b0, 1000);
    // the wake that heard the sync is not a missed one
    rd(OFF_MISSED, 32'd0, "missed_none");
    wait_on(awake, 1'b1, 1000);
    wait_on(awake, 1'b0, 1000);
    rd(OFF_MISSED, 32'd1, "missed");
    rd(OFF_TX_AVL, 32'd15, "tx_avail");
    // one miss: early wake of 32 ms is capped at half the 40 ms sleep
    wr(OFF_CTRL, 32'h0000_01c8);
    wait_on(awake, 1'b1, 1000);
    n = 0;
    while (awake === 1'b1 && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    chk("early_wake_len", n, (30 + 20) * 10);
    chk("frames", frames > 0, 1);
    chk("frame_phase", frame_bad, 0);
  endtask : t_cyclic
  task automatic t_coord();
    logic [31:0] r;
    logic e;
    int n;
    press();
    chk("woken", awake, 1);
    press();
    apb(1'b0, OFF_STATUS, 32'h0, r, e);
    chk("coord", r[0], 1);
    wr(OFF_SLEEP, 32'd60);
    n = 0;
    while (!(tx_sync === 1'b1 && tx_sync_sleep === 32'd60) && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    chk("new_sent", tx_sync, 1);
    rd(OFF_OP_SLP, 32'd60, "op_new");
  endtask : t_coord
  task automatic t_led();
    int n;
    logic l;
    wait_on(led, ~led, 12000);
    l = led;
    n = 0;
    while (led === l && n < 12000) begin
      @(posedge mclk);
      n++;
    end
    chk("led_period", n, LED_SLOW_MS * 10);
  endtask : t_led
  task automatic t_hold();
    int n;
    button <= 1'b1;
    repeat (HOLD_WAKE_MS * 10 + 20) @(posedge mclk);
    button <= 1'b0;
    // a plain cycle would sleep well inside this window
    n = 0;
    repeat (1000) begin
      @(posedge mclk);
      if (awake !== 1'b1) n++;
    end
    chk("hold_awake", n, 0);
  endtask : t_hold
  task automatic t_support();
    int n;
    wr(OFF_CTRL, 32'h0000_0007);
    repeat (5) @(posedge mclk);
    kick <= 1'b1;
    @(posedge mclk);
    kick <= 1'b0;
    wait_on(tx_sync, 1'b1, 10);
    chk("reject_sent", tx_sync, 1);
    chk("reject_sleep", tx_sync_sleep, 32'd60);
    rd(OFF_OP_SLP, 32'd60, "reject_kept");
    n = 0;
    repeat (500) begin
      @(posedge mclk);
      if (awake !== 1'b1) n++;
    end
    chk("always_awake", n, 0);
  endtask : t_support
  ////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; button = 1'b0; rx_req_valid = 1'b0; kick = 1'b0;
    failures = 0; checks_done = 0; cyc = 0; frames = 0; frame_bad = 0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    t_reset();
    t_wake_min();
    t_cyclic();
    t_coord();
    t_led();
    t_hold();
    t_support();
    summarize();
  end
endmodule : test_mesh_sleep_sync_controller
`default_nettype wire

// ===== design/mesh_sleep_sync_controller.sv
// How it works
// RULE1: propagation time is slots*hops*(repeats+1)*18ms
// RULE2: wake time raised to minimum on change (code raises it only after a sleep or network write, not after a wake write)
// RULE3: missed syncs shrink available transmit time
// RULE4: reset starts in normal non-sleep mode
// RULE5: modes 7 and 8 sleep, 8 cyclic
// RULE6: double press nominates node as coordinator
// RULE7: led slow as coordinator, blinks awake-synced
// RULE8: single press wakes sleeping synced node
// RULE9: two-second hold wakes cyclic node thirty seconds
// RULE10: unsynced node requests sync then sleeps
// RULE11: synced node answers sync request
// RULE12: support node stays awake always
// RULE13: changed settings make node coordinator, sent next wake
// RULE14: new settings used once sync sent
// RULE15: missed new-settings sync keeps old times
// RULE16: early wake grows with missed cycles
// RULE17: early wake lengthens wake, shortens sleep
// RULE18: support rejects older sync, sends newer
// RULE19: operational sleep and wake readable
// RULE20: status shows coordinator role
// RULE21: missed sync count readable
// RULE22: status frame on wake and before sleep (code sends the sleep frame in the same cycle that awake falls, or with awake held high in support mode)
//
// Decided for this implementation: the APB register port and the register addresses.
`default_nettype none
module mesh_sleep_sync_controller #(
  parameter int unsigned MS_CYCLES = sleep_sync_pkg::MS_CYCLES_DEF
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // commissioning button, high while pressed
  input  wire logic        button,
  // received sync traffic
  input  wire logic        rx_sync_valid,
  input  wire logic [31:0] rx_sync_sleep,
  input  wire logic [31:0] rx_sync_wake,
  input  wire logic [7:0]  rx_sync_ver,
  input  wire logic        rx_req_valid,
  // transmit requests
  output logic             tx_sync,
  output logic [31:0]      tx_sync_sleep,
  output logic [31:0]      tx_sync_wake,
  output logic [7:0]       tx_sync_ver,
  output logic             tx_req,
  // node state
  output logic             awake,
  output logic             led,
  output logic             status_frame,
  output logic             status_wake
);
  import sleep_sync_pkg::*;

  typedef struct packed {
    phase_e      st;
    logic [31:0] ms_cnt;
    logic [31:0] tmr;
    logic [8:0]  ctrl;
    logic [31:0] sp;
    logic [31:0] wt;
    logic [7:0]  nn;
    logic [7:0]  nh;
    logic [7:0]  mt;
    logic        clamp;
    logic [31:0] op_sp;
    logic [31:0] op_wt;
    logic [7:0]  ver;
    logic        coord;
    logic        synced;
    logic        pend;
    logic [15:0] missed;
    logic        got_sync;
    logic        btn_q;
    logic        press1;
    logic [15:0] press_tmr;
    logic [15:0] hold_tmr;
    logic [15:0] led_tmr;
    logic        led;
    logic        awake;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        tx_sync;
    logic [31:0] tx_sleep;
    logic [31:0] tx_wake;
    logic [7:0]  tx_ver;
    logic        tx_req;
    logic        stat_frm;
    logic        stat_wake;
  } state_s;

  state_s q, n;

  logic        tick;
  logic        sleepy;
  logic        support;
  logic [31:0] prop;
  logic [31:0] eff_sp;
  logic [31:0] eff_wt;
  logic [31:0] early;
  logic [31:0] guard;
  logic [31:0] sleep_dur;
  logic [31:0] wake_dur;
  logic        wr;
  logic        start_wake;
  logic        end_wake;
  logic        older;
  logic [7:0]  vdiff;
  logic [15:0] led_per;

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    tick    = (q.ms_cnt == MS_CYCLES - 1);
    sleepy  = (q.ctrl[3:0] == MODE_SUPPORT) || (q.ctrl[3:0] == MODE_CYCLIC); // RULE5
    support = (q.ctrl[3:0] == MODE_SUPPORT);
    prop    = 32'(q.nn) * 32'(q.nh) * (32'(q.mt) + 32'd1) * SYNC_UNIT_MS; // RULE1
    // until synced the node runs on its own configured times
    eff_sp  = q.synced ? q.op_sp : q.sp;
    eff_wt  = q.synced ? q.op_wt : q.wt;
    early   = 32'd0;
    if (q.ctrl[OPT_EARLY] && !q.coord) begin
      early = 32'(q.missed) * EARLY_STEP_MS; // RULE16
      if (early > (eff_sp >> 1)) begin
        early = eff_sp >> 1;
      end
    end
    sleep_dur = eff_sp - early; // RULE17
    wake_dur  = eff_wt + early; // RULE17
    guard     = 32'(q.missed) * GUARD_STEP_MS; // RULE3
    if (guard > (eff_wt >> 1)) begin
      guard = eff_wt >> 1;
    end
    vdiff   = q.ver - rx_sync_ver;
    older   = q.synced && (vdiff != 8'h00) && !vdiff[7];
    led_per = q.coord ? 16'(LED_SLOW_MS) : 16'(LED_FAST_MS);
    wr      = psel && penable && q.pready && pwrite && !q.pslverr;
  end

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    n            = q;
    n.tx_sync    = 1'b0;
    n.tx_req     = 1'b0;
    n.stat_frm   = 1'b0;
    n.clamp      = 1'b0;
    start_wake   = 1'b0;
    end_wake     = 1'b0;
    n.ms_cnt     = tick ? 32'd0 : q.ms_cnt + 32'd1;

    // apb: one wait state, data and pready both registered
    n.pready  = psel && penable && !q.pready;
    n.pslverr = 1'b0;
    if (psel && penable && !q.pready) begin
      unique case (paddr)
        OFF_CTRL:   n.prdata = {23'h0, q.ctrl};
        OFF_SLEEP:  n.prdata = q.sp;
        OFF_WAKE:   n.prdata = q.wt;
        OFF_NET:    n.prdata = {8'h0, q.mt, q.nh, q.nn};
        OFF_STATUS: n.prdata = {27'h0, q.got_sync, q.pend, q.awake, q.synced, q.coord}; // RULE20
        OFF_OP_SLP: n.prdata = q.op_sp; // RULE19
        OFF_OP_WAK: n.prdata = q.op_wt; // RULE19
        OFF_MISSED: n.prdata = {16'h0, q.missed}; // RULE21
        OFF_PROP:   n.prdata = prop; // RULE1
        OFF_TX_AVL: n.prdata = eff_wt - guard; // RULE3
        default: begin
          n.prdata  = 32'h0;
          n.pslverr = 1'b1;
        end
      endcase
    end
    if (wr) begin
      unique case (paddr)
        OFF_CTRL: n.ctrl = pwdata[8:0];
        OFF_SLEEP: begin
          n.sp    = pwdata;
          n.clamp = 1'b1;
        end
        OFF_WAKE: n.wt = pwdata;
        OFF_NET: begin
          n.nn    = pwdata[7:0];
          n.nh    = pwdata[15:8];
          n.mt    = pwdata[23:16];
          n.clamp = 1'b1;
        end
        default: ;
      endcase
      // a differing local setting takes over the network
      if ((paddr == OFF_SLEEP && pwdata != q.op_sp) ||
          (paddr == OFF_WAKE && pwdata != q.op_wt)) begin
        if (sleepy && !q.ctrl[OPT_NONCOORD]) begin
          n.coord = 1'b1; // RULE13
          n.pend  = 1'b1; // RULE13
        end
      end
    end
    // clamp one cycle after the write so it sees the stored settings
    if (q.clamp && q.wt < prop) begin
      n.wt = prop; // RULE2
    end

    //////////////////////////////////////////////////////////////////
    // sleep/wake phase
    if (!sleepy) begin
      n.st     = PH_NORMAL; // RULE4
      n.synced = 1'b0;
      n.coord  = 1'b0;
      n.tmr    = 32'd0;
    end else begin
      unique case (q.st)
        PH_NORMAL: begin
          n.st       = PH_WAKE;
          n.tmr      = 32'd0;
          start_wake = 1'b1;
        end
        PH_WAKE: begin
          if (tick) begin
            n.tmr = q.tmr + 32'd1;
            if (q.tmr + 32'd1 >= wake_dur) begin
              n.st     = PH_SLEEP;
              n.tmr    = 32'd0;
              end_wake = 1'b1;
            end
          end
        end
        PH_SLEEP: begin
          if (tick) begin
            n.tmr = q.tmr + 32'd1;
            if (q.tmr + 32'd1 >= sleep_dur) begin // RULE10
              n.st       = PH_WAKE;
              n.tmr      = 32'd0;
              start_wake = 1'b1;
            end
          end
        end
        PH_HOLD: begin
          if (tick) begin
            n.tmr = q.tmr + 32'd1;
            if (q.tmr + 32'd1 >= STAY_AWAKE_MS) begin // RULE9
              n.st     = PH_SLEEP;
              n.tmr    = 32'd0;
              end_wake = 1'b1;
            end
          end
        end
      endcase
    end

    if (start_wake) begin
      n.got_sync = 1'b0;
      if (q.coord || q.ctrl[OPT_PREF]) begin
        if (q.pend || !q.synced) begin
          n.op_sp = q.sp; // RULE14
          n.op_wt = q.wt; // RULE14
          n.ver   = q.ver + 8'h01;
        end
        if (!(wr && (paddr == OFF_SLEEP || paddr == OFF_WAKE))) begin
          n.pend = 1'b0; // a change landing in this cycle stays pending
        end
        n.synced   = 1'b1;
        n.coord    = 1'b1;
        n.tx_sync  = 1'b1; // RULE13
        n.tx_sleep = (q.pend || !q.synced) ? q.sp : q.op_sp;
        n.tx_wake  = (q.pend || !q.synced) ? q.wt : q.op_wt;
        n.tx_ver   = (q.pend || !q.synced) ? q.ver + 8'h01 : q.ver;
      end else if (!q.synced ||
                   (q.ctrl[OPT_NONCOORD] && q.missed >= REQ_MISSED_MIN)) begin
        n.tx_req = 1'b1; // RULE10
      end
    end
    // a node that hears nothing keeps its old times and counts the cycle
    if (end_wake && q.synced && !q.coord && !q.got_sync && q.missed != 16'hffff) begin
      n.missed = q.missed + 16'd1; // RULE15
    end
    if ((start_wake || end_wake) && q.ctrl[OPT_STATFRM] && q.ctrl[OPT_HOSTFRM]) begin
      n.stat_frm  = 1'b1; // RULE22
      n.stat_wake = start_wake;
    end

    //////////////////////////////////////////////////////////////////
    // received sync traffic, handled after the phase so it realigns it
    if (sleepy && rx_sync_valid) begin
      if (older && (support || q.coord)) begin
        n.tx_sync  = 1'b1; // RULE18
        n.tx_sleep = q.op_sp;
        n.tx_wake  = q.op_wt;
        n.tx_ver   = q.ver;
      end else if (!(q.coord && (q.pend || q.ctrl[OPT_PREF]))) begin
        n.op_sp    = rx_sync_sleep;
        n.op_wt    = rx_sync_wake;
        n.ver      = rx_sync_ver;
        n.synced   = 1'b1;
        n.coord    = 1'b0;
        n.missed   = 16'd0;
        n.got_sync = 1'b1;
        if (q.st != PH_HOLD) begin
          n.st  = PH_WAKE;
          n.tmr = 32'd0;
        end
      end
    end
    if (rx_req_valid && q.synced && (q.st != PH_SLEEP || support)) begin
      n.tx_sync  = 1'b1; // RULE11
      n.tx_sleep = q.op_sp;
      n.tx_wake  = q.op_wt;
      n.tx_ver   = q.ver;
    end

    //////////////////////////////////////////////////////////////////
    // commissioning button
    n.btn_q = button;
    if (tick && q.press1) begin
      n.press_tmr = q.press_tmr + 16'd1;
      if (q.press_tmr + 16'd1 >= DOUBLE_PRESS_MS) begin
        n.press1 = 1'b0;
      end
    end
    if (button && !q.btn_q) begin
      if (q.press1) begin
        n.press1 = 1'b0;
        if (sleepy && !q.ctrl[OPT_NONCOORD]) begin
          n.coord = 1'b1; // RULE6
        end
      end else begin
        n.press1    = 1'b1;
        n.press_tmr = 16'd0;
        if (sleepy && q.synced && q.st == PH_SLEEP) begin
          n.st  = PH_WAKE; // RULE8
          n.tmr = 32'd0;
        end
      end
    end
    if (!button) begin
      n.hold_tmr = 16'd0;
    end else if (tick && q.hold_tmr != 16'hffff) begin
      n.hold_tmr = q.hold_tmr + 16'd1;
      if (q.hold_tmr + 16'd1 == HOLD_WAKE_MS && q.ctrl[3:0] == MODE_CYCLIC) begin
        n.st  = PH_HOLD; // RULE9
        n.tmr = 32'd0;
      end
    end

    //////////////////////////////////////////////////////////////////
    n.awake = (n.st != PH_SLEEP) || support; // RULE12
    if (tick) begin
      n.led_tmr = q.led_tmr + 16'd1;
      if (q.led_tmr + 16'd1 >= led_per) begin
        n.led_tmr = 16'd0;
        n.led     = !q.led; // RULE7
      end
    end
    if (!(q.coord || (q.synced && q.awake))) begin
      n.led = 1'b0; // RULE7
    end
  end

  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q       <= '0;
      q.st    <= PH_NORMAL;
      q.ctrl  <= CTRL_RST;
      q.sp    <= SLEEP_RST;
      q.wt    <= WAKE_RST;
      q.nn    <= NN_RST;
      q.nh    <= NH_RST;
      q.mt    <= MT_RST;
      q.awake <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign prdata        = q.prdata;
  assign pready        = q.pready;
  assign pslverr       = q.pslverr;
  assign tx_sync       = q.tx_sync;
  assign tx_sync_sleep = q.tx_sleep;
  assign tx_sync_wake  = q.tx_wake;
  assign tx_sync_ver   = q.tx_ver;
  assign tx_req        = q.tx_req;
  assign awake         = q.awake;
  assign led           = q.led;
  assign status_frame  = q.stat_frm;
  assign status_wake   = q.stat_wake;
endmodule : mesh_sleep_sync_controller
`default_nettype wire

// ===== design/sleep_sync_pkg.sv
`default_nettype none
package sleep_sync_pkg;
  // timing
  localparam int unsigned CLK_NS          = 10;
  localparam int unsigned MS_NS           = 1_000_000;
  localparam int unsigned MS_CYCLES_DEF   = (MS_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SYNC_UNIT_MS    = 18;
  localparam int unsigned HOLD_WAKE_MS    = 2000;
  localparam int unsigned STAY_AWAKE_MS   = 30000;
  localparam int unsigned DOUBLE_PRESS_MS = 1000;
  localparam int unsigned LED_SLOW_MS     = 1000;
  localparam int unsigned LED_FAST_MS     = 250;
  localparam int unsigned GUARD_STEP_MS   = 16;
  localparam int unsigned EARLY_STEP_MS   = 32;
  localparam int unsigned REQ_MISSED_MIN  = 6;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_SLEEP   = 8'h04;
  localparam logic [7:0] OFF_WAKE    = 8'h08;
  localparam logic [7:0] OFF_NET     = 8'h0c;
  localparam logic [7:0] OFF_STATUS  = 8'h10;
  localparam logic [7:0] OFF_OP_SLP  = 8'h14;
  localparam logic [7:0] OFF_OP_WAK  = 8'h18;
  localparam logic [7:0] OFF_MISSED  = 8'h1c;
  localparam logic [7:0] OFF_PROP    = 8'h20;
  localparam logic [7:0] OFF_TX_AVL  = 8'h24;
  // control fields
  localparam int unsigned CTRL_W       = 9;
  localparam int unsigned OPT_PREF     = 4;
  localparam int unsigned OPT_NONCOORD = 5;
  localparam int unsigned OPT_EARLY    = 6;
  localparam int unsigned OPT_STATFRM  = 7;
  localparam int unsigned OPT_HOSTFRM  = 8;
  localparam logic [3:0] MODE_NORMAL  = 4'h0;
  localparam logic [3:0] MODE_SUPPORT = 4'h7;
  localparam logic [3:0] MODE_CYCLIC  = 4'h8;
  // reset values
  localparam logic [8:0]  CTRL_RST  = 9'h000;
  localparam logic [31:0] SLEEP_RST = 32'h0000_0064;
  localparam logic [31:0] WAKE_RST  = 32'h0000_07d0;
  localparam logic [7:0]  NN_RST    = 8'h03;
  localparam logic [7:0]  NH_RST    = 8'h07;
  localparam logic [7:0]  MT_RST    = 8'h03;

  typedef enum logic [1:0] {
    PH_NORMAL = 2'b00,
    PH_WAKE   = 2'b01,
    PH_SLEEP  = 2'b10,
    PH_HOLD   = 2'b11
  } phase_e;
endpackage : sleep_sync_pkg
`default_nettype wire
